// ### rtl/partition_monitor_pkg.sv
/*
 * Constants of the feature identification bank: frame offsets, field
 * positions and the feature values that the bank reports.
 * Assumes the identification values are fixed when the chip is built.
 */
package partition_monitor_pkg;

    // Offsets inside a feature frame
    localparam logic [15:0] OFF_SECURE_LIMITS = 16'h0008;
    localparam logic [15:0] OFF_PRIORITY = 16'h0048;
    localparam logic [15:0] OFF_NARROWING = 16'h0050;
    localparam logic [15:0] OFF_MONITOR = 16'h0080;

    // Field positions, monitor feature word
    localparam int MON_LOCAL_CAPTURE_BIT = 31;
    localparam int MON_BANDWIDTH_BIT = 17;
    localparam int MON_CACHE_BIT = 16;
    // Field positions, priority feature word
    localparam int PRI_DS_WIDTH_LSB = 20;
    localparam int PRI_DS_ZERO_LOW_BIT = 17;
    localparam int PRI_DS_PRESENT_BIT = 16;
    localparam int PRI_INT_WIDTH_LSB = 4;
    localparam int PRI_INT_ZERO_LOW_BIT = 1;
    localparam int PRI_INT_PRESENT_BIT = 0;
    // Field positions, limit words
    localparam int NRW_LIMIT_LSB = 0;
    localparam int SEC_GROUP_LSB = 16;
    localparam int SEC_PARTITION_LSB = 0;

    // Word shown for reserved space and absent registers
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Component-wide presence flags
    localparam logic MONITORING_PRESENT = 1'b1;
    localparam logic NARROWING_PRESENT = 1'b1;
    localparam logic PRIORITY_PARTITIONING_PRESENT = 1'b1;

    // Secure frame feature values
    localparam logic S_LOCAL_CAPTURE = 1'b1;
    localparam logic S_BANDWIDTH_MON = 1'b1;
    localparam logic S_CACHE_MON = 1'b1;
    localparam logic [15:0] S_INTERNAL_PARTITION_LIMIT = 16'h001f;
    localparam logic [5:0] S_DS_WIDTH = 6'h04;
    localparam logic S_DS_ZERO_LOWEST = 1'b0;
    localparam logic [5:0] S_INT_WIDTH = 6'h03;
    localparam logic S_INT_ZERO_LOWEST = 1'b1;
    localparam logic [7:0] SECURE_GROUP_LIMIT = 8'h01;
    localparam logic [15:0] SECURE_PARTITION_LIMIT = 16'h000f;

    // Non-secure frame feature values; may differ from the secure ones
    localparam logic NS_LOCAL_CAPTURE = 1'b0;
    localparam logic NS_BANDWIDTH_MON = 1'b1;
    localparam logic NS_CACHE_MON = 1'b1;
    localparam logic [15:0] NS_INTERNAL_PARTITION_LIMIT = 16'h003f;
    localparam logic [5:0] NS_DS_WIDTH = 6'h00;
    localparam logic NS_DS_ZERO_LOWEST = 1'b0;
    localparam logic [5:0] NS_INT_WIDTH = 6'h03;
    localparam logic NS_INT_ZERO_LOWEST = 1'b1;

    // Bus sequencer states
    typedef enum logic [0:0] {ST_STRAP, ST_RUN} bank_state_t;

endpackage

// ### rtl/feature_frame_view.sv
/*
 * One feature frame of the identification bank: packs the frame's feature
 * values into register words and decodes a frame offset to a word.
 * Assumes the offset is stable while the caller samples the result.
 */
`timescale 1ns/10ps
`default_nettype none

module feature_frame_view
    import partition_monitor_pkg::*;
#(
    parameter bit IS_SECURE = 1'b0,
    parameter bit LOCAL_CAPTURE = 1'b0,
    parameter bit BANDWIDTH_MON = 1'b0,
    parameter bit CACHE_MON = 1'b0,
    parameter logic [15:0] PARTITION_LIMIT = 16'h0000,
    parameter logic [5:0] DS_WIDTH = 6'h00,
    parameter bit DS_ZERO_LOWEST = 1'b0,
    parameter logic [5:0] INT_WIDTH = 6'h00,
    parameter bit INT_ZERO_LOWEST = 1'b0
) (
    // Lookup
    input wire logic [15:0] offset,
    input wire logic secure_map_ok,
    // Result
    output logic [31:0] word,
    output logic hit
);

    logic [31:0] monitor_word;
    logic [31:0] priority_word;
    logic [31:0] narrowing_word;
    logic [31:0] limits_word;

    // Pack each word; every bit not assigned stays zero
    always_comb begin
        monitor_word = WORD_ZERO;
        monitor_word[MON_LOCAL_CAPTURE_BIT] = LOCAL_CAPTURE;
        monitor_word[MON_BANDWIDTH_BIT] = BANDWIDTH_MON;
        monitor_word[MON_CACHE_BIT] = CACHE_MON;
        priority_word = WORD_ZERO;
        priority_word[PRI_DS_WIDTH_LSB +: 6] = DS_WIDTH;
        priority_word[PRI_DS_ZERO_LOW_BIT] = DS_ZERO_LOWEST;
        priority_word[PRI_DS_PRESENT_BIT] = (DS_WIDTH != 6'h00);
        priority_word[PRI_INT_WIDTH_LSB +: 6] = INT_WIDTH;
        priority_word[PRI_INT_ZERO_LOW_BIT] = INT_ZERO_LOWEST;
        priority_word[PRI_INT_PRESENT_BIT] = (INT_WIDTH != 6'h00);
        narrowing_word = WORD_ZERO;
        narrowing_word[NRW_LIMIT_LSB +: 16] = PARTITION_LIMIT;
        limits_word = WORD_ZERO;
        limits_word[SEC_GROUP_LSB +: 8] = SECURE_GROUP_LIMIT;
        limits_word[SEC_PARTITION_LSB +: 16] = SECURE_PARTITION_LIMIT;
    end

    // Offset decode; absent registers read as reserved zero
    always_comb begin
        word = WORD_ZERO;
        hit = 1'b0;
        unique case (offset)
            OFF_MONITOR: begin
                hit = MONITORING_PRESENT;
                word = MONITORING_PRESENT ? monitor_word : WORD_ZERO;
            end
            OFF_NARROWING: begin
                hit = NARROWING_PRESENT;
                word = NARROWING_PRESENT ? narrowing_word : WORD_ZERO;
            end
            OFF_PRIORITY: begin
                hit = PRIORITY_PARTITIONING_PRESENT;
                word = PRIORITY_PARTITIONING_PRESENT ? priority_word : WORD_ZERO;
            end
            OFF_SECURE_LIMITS: begin
                hit = IS_SECURE && secure_map_ok;
                word = (IS_SECURE && secure_map_ok) ? limits_word : WORD_ZERO;
            end
            default: begin
                hit = 1'b0;
                word = WORD_ZERO;
            end
        endcase
    end

endmodule // feature_frame_view

`default_nettype wire

// ### rtl/partition_monitor_feature_ids.sv
/*
 * Read-only feature identification bank seen through a secure and a
 * non-secure feature frame.
 * Assumes a simple request port: one request per cycle when ready, the
 * answer one cycle later; the secure-map strap is steady around reset.
 */
// Functional notes
// - Separate secure and non-secure copies where contents differ
// - Monitor feature word at 0x0080, read-only
// - Narrowing limit in bits 15:0, upper zero
// - Narrowing limit word at 0x0050, read-only
// - Priority word reads zero without priority partitioning
// - Bits 25:20 give downstream priority width
// - Bit 17 gives downstream zero-lowest polarity
// - Bit 16 flags downstream priority field present
// - Bits 9:4 give internal priority width
// - Bit 1 gives internal zero-lowest polarity
// - Bit 0 flags internal priority field present
// - Priority word at 0x0048, read-only
// - Secure group limit bits 23:16, top zero
// - Secure partition limit in bits 15:0
// - Secure limits only in secure frame 0x0008
// - No secure map means no secure limits
// - Monitor bit 31 flags local capture generator
// - Monitor bit 17 flags bandwidth usage monitoring
// - Monitor bit 16 flags cache usage monitoring
`timescale 1ns/10ps
`default_nettype none

module partition_monitor_feature_ids
    import partition_monitor_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Strap: the system provides a secure address map
    input wire logic secure_map_present,
    // Request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_secure,
    input wire logic [15:0] req_addr,
    output logic req_ready,
    // Answer
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    output logic resp_unmapped
);

    bank_state_t state_reg, state_next;
    logic secure_map_reg, secure_map_next;
    logic resp_valid_reg, resp_valid_next;
    logic [31:0] resp_rdata_reg, resp_rdata_next;
    logic resp_unmapped_reg, resp_unmapped_next;
    logic [31:0] secure_word;
    logic [31:0] nonsecure_word;
    logic secure_hit;
    logic nonsecure_hit;
    logic take;

    // Secure frame copy
    feature_frame_view #(
        .IS_SECURE(1'b1),
        .LOCAL_CAPTURE(S_LOCAL_CAPTURE),
        .BANDWIDTH_MON(S_BANDWIDTH_MON),
        .CACHE_MON(S_CACHE_MON),
        .PARTITION_LIMIT(S_INTERNAL_PARTITION_LIMIT),
        .DS_WIDTH(S_DS_WIDTH),
        .DS_ZERO_LOWEST(S_DS_ZERO_LOWEST),
        .INT_WIDTH(S_INT_WIDTH),
        .INT_ZERO_LOWEST(S_INT_ZERO_LOWEST)
    ) secure_frame (
        .offset(req_addr),
        .secure_map_ok(secure_map_reg),
        .word(secure_word),
        .hit(secure_hit)
    );

    // Non-secure frame copy, distinct because its values differ
    feature_frame_view #(
        .IS_SECURE(1'b0),
        .LOCAL_CAPTURE(NS_LOCAL_CAPTURE),
        .BANDWIDTH_MON(NS_BANDWIDTH_MON),
        .CACHE_MON(NS_CACHE_MON),
        .PARTITION_LIMIT(NS_INTERNAL_PARTITION_LIMIT),
        .DS_WIDTH(NS_DS_WIDTH),
        .DS_ZERO_LOWEST(NS_DS_ZERO_LOWEST),
        .INT_WIDTH(NS_INT_WIDTH),
        .INT_ZERO_LOWEST(NS_INT_ZERO_LOWEST)
    ) nonsecure_frame (
        .offset(req_addr),
        .secure_map_ok(secure_map_reg),
        .word(nonsecure_word),
        .hit(nonsecure_hit)
    );

    // Ready once the strap has been caught after reset release
    assign req_ready = (state_reg == ST_RUN);
    assign take = req_valid && req_ready;

    // Next state: strap capture, then request handling
    always_comb begin
        state_next = state_reg;
        secure_map_next = secure_map_reg;
        resp_valid_next = 1'b0;
        resp_rdata_next = resp_rdata_reg;
        resp_unmapped_next = 1'b0;
        unique case (state_reg)
            ST_STRAP: begin
                secure_map_next = secure_map_present;
                state_next = ST_RUN;
            end
            ST_RUN: begin
                if (take) begin
                    resp_valid_next = 1'b1;
                    if (req_write) begin
                        // Acknowledged with no effect on any state
                        resp_rdata_next = WORD_ZERO;
                        resp_unmapped_next = 1'b0;
                    end else if (req_secure && secure_map_reg) begin
                        resp_rdata_next = secure_word;
                        resp_unmapped_next = !secure_hit;
                    end else if (req_secure) begin
                        // No secure map: the secure frame does not exist
                        resp_rdata_next = WORD_ZERO;
                        resp_unmapped_next = 1'b1;
                    end else begin
                        resp_rdata_next = nonsecure_word;
                        resp_unmapped_next = !nonsecure_hit;
                    end
                end
            end
        endcase
    end

    // Registers of the sequencer and the answer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_STRAP;
            secure_map_reg <= 1'b0;
            resp_valid_reg <= 1'b0;
            resp_rdata_reg <= WORD_ZERO;
            resp_unmapped_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            secure_map_reg <= secure_map_next;
            resp_valid_reg <= resp_valid_next;
            resp_rdata_reg <= resp_rdata_next;
            resp_unmapped_reg <= resp_unmapped_next;
        end
    end

    // Answer outputs straight from flip-flops
    assign resp_valid = resp_valid_reg;
    assign resp_rdata = resp_rdata_reg;
    assign resp_unmapped = resp_unmapped_reg;

endmodule // partition_monitor_feature_ids

`default_nettype wire

// ### verification/feature_ids_properties.sv
/* Checker for the answer port of the feature bank.
   Assumes it is bound to the bank's top module. */
`timescale 1ns/10ps
`default_nettype none
module feature_ids_checker
    import partition_monitor_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Request and answer
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_secure,
    input wire logic [15:0] req_addr,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic [31:0] resp_rdata,
    input wire logic resp_unmapped
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A taken request, and a taken read at one offset
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_read(logic [15:0] a);
        req_valid && req_ready && !req_write && req_addr == a;
    endsequence
    // Answer timing and read-only behaviour
    a_answer_one_cycle: assert property (s_take |=> resp_valid) else $error("no answer");
    a_no_spurious_answer: assert property (!(req_valid && req_ready) |=> !resp_valid)
        else $error("answer without request");
    a_rdata_holds: assert property (!(req_valid && req_ready) |=> $stable(resp_rdata))
        else $error("read data moved");
    a_write_reads_zero: assert property (req_valid && req_ready && req_write
        |=> resp_rdata == 32'h0000_0000 && !resp_unmapped) else $error("write answer");
    // Layout of each word
    a_limits_hidden_ns: assert property (s_read(OFF_SECURE_LIMITS) ##0 !req_secure
        |=> resp_unmapped && resp_rdata == 32'h0000_0000) else $error("limits visible");
    a_secure_top_zero: assert property (s_read(OFF_SECURE_LIMITS)
        |=> resp_rdata[31:24] == 8'h00) else $error("limits top bits");
    a_narrow_upper_zero: assert property (s_read(OFF_NARROWING)
        |=> resp_rdata[31:16] == 16'h0000) else $error("narrowing top bits");
    a_monitor_reserved: assert property (s_read(OFF_MONITOR)
        |=> resp_rdata[30:18] == 13'h0000 && resp_rdata[15:0] == 16'h0000)
        else $error("monitor reserved bits");
    a_priority_fields: assert property (s_read(OFF_PRIORITY)
        |=> resp_rdata[31:26] == 6'h00 && resp_rdata[19:18] == 2'b00
        && resp_rdata[15:10] == 6'h00 && resp_rdata[3:2] == 2'b00
        && resp_rdata[16] == (resp_rdata[25:20] != 6'h00) && resp_rdata[25:20] <= 6'h20
        && resp_rdata[0] == (resp_rdata[9:4] != 6'h00) && resp_rdata[9:4] <= 6'h20)
        else $error("priority fields");
endmodule // feature_ids_checker

bind partition_monitor_feature_ids feature_ids_checker u_checker (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req_write(req_write), .req_secure(req_secure),
    .req_addr(req_addr), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .resp_unmapped(resp_unmapped));
`default_nettype wire

// ### verification/tb.sv
/* Self-checking bench for the feature bank: fixed and random reads and
   writes in both frames, with and without the secure-map strap.
   Assumes the one-cycle answer of the bank's request port. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import partition_monitor_pkg::*;
    localparam logic [32:0] UNMAPPED = {1'b1, 32'h0000_0000};
    logic clock, rst_n, secure_map_present, req_valid, req_write, req_secure;
    logic req_ready, resp_valid, resp_unmapped, pend;
    logic [15:0] req_addr;
    logic [31:0] resp_rdata;
    logic [32:0] pend_exp;
    int n_errors, n_compared, seed, i;
    logic [15:0] offs [4] = '{OFF_SECURE_LIMITS, OFF_PRIORITY, OFF_NARROWING, OFF_MONITOR};

    partition_monitor_feature_ids DUT (.clock(clock), .rst_n(rst_n),
        .secure_map_present(secure_map_present), .req_valid(req_valid),
        .req_write(req_write), .req_secure(req_secure), .req_addr(req_addr),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .resp_unmapped(resp_unmapped));

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Answer word and unmapped flag that a request should produce
    function automatic logic [32:0] expect_word(logic wr, logic sec, logic [15:0] a);
        logic [5:0] dw;
        logic [5:0] iw;
        dw = sec ? S_DS_WIDTH : NS_DS_WIDTH;
        iw = sec ? S_INT_WIDTH : NS_INT_WIDTH;
        if (wr) return 33'h0_0000_0000;
        if (sec && !secure_map_present) return UNMAPPED;
        case (a)
            OFF_MONITOR: return {1'b0, sec ? S_LOCAL_CAPTURE : NS_LOCAL_CAPTURE, 13'h0000,
                sec ? S_BANDWIDTH_MON : NS_BANDWIDTH_MON, sec ? S_CACHE_MON : NS_CACHE_MON,
                16'h0000};
            OFF_NARROWING: return {17'h0_0000,
                sec ? S_INTERNAL_PARTITION_LIMIT : NS_INTERNAL_PARTITION_LIMIT};
            OFF_PRIORITY: return {7'h00, dw, 2'b00, sec ? S_DS_ZERO_LOWEST : NS_DS_ZERO_LOWEST,
                dw != 6'h00, 6'h00, iw, 2'b00, sec ? S_INT_ZERO_LOWEST : NS_INT_ZERO_LOWEST,
                iw != 6'h00};
            OFF_SECURE_LIMITS: return sec ? {9'h000, SECURE_GROUP_LIMIT, SECURE_PARTITION_LIMIT}
                : UNMAPPED;
            default: return UNMAPPED;
        endcase
    endfunction

    // Checks the answer due at this falling edge, then drives the next request
    task automatic step(input logic v, input logic wr, input logic sec, input logic [15:0] a);
        @(negedge clock);
        check({32'h0000_0000, resp_valid}, {32'h0000_0000, pend});
        if (pend) check({resp_unmapped, resp_rdata}, pend_exp);
        if (pend) check({resp_unmapped, resp_rdata}, pend_exp);
        if (pend) check({resp_unmapped, resp_rdata}, pend_exp);
        req_valid = v;
        req_write = wr;
        req_secure = sec;
        req_addr = a;
        pend = v && req_ready;
        pend_exp = expect_word(wr, sec, a);
    endtask

    // Two passes: strap high, then a mid-run reset with strap low
    initial begin
        seed = 34508;
        n_errors = 0;
        n_compared = 0;
        pend = 1'b0;
        secure_map_present = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_secure = 1'b0;
        req_addr = 16'h0000;
        for (int pass = 0; pass < 2; pass++) begin
            rst_n = 1'b0;
            pend = 1'b0;
            repeat (10) @(negedge clock);
            // Held in reset: no answer, cleared data, not ready
            check({resp_unmapped, resp_rdata}, 33'h0_0000_0000);
            check({31'h0000_0000, req_ready, resp_valid}, 33'h0_0000_0000);
            secure_map_present = (pass == 0);
            rst_n = 1'b1;
            for (i = 0; i < 20 && req_ready !== 1'b1; i++) step(1'b0, 1'b0, 1'b0, 16'h0000);
            // Ready follows the strap capture on the first edge; a timeout fails here
            check(33'(i), 33'h0_0000_0001);
            if (i == 20) begin
                break;
            end
            for (i = 0; i < 16; i++) step(1'b1, i[3], i[2], offs[i[1:0]]);
            for (i = 0; i < 60; i++) begin
                step(1'($random(seed)), 2'($random(seed)) == 2'b00, 1'($random(seed)),
                    1'($random(seed)) ? offs[2'($random(seed))] : 16'($random(seed)));
            end
            step(1'b0, 1'b0, 1'b0, 16'h0000);
        end
        step(1'b0, 1'b0, 1'b0, 16'h0000);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
